//--- bcm_adc_model.sv
// Behavioural converter that answers the core's start pulses
`timescale 1ns/100ps
`default_nettype none
module bcm_adc_model
    import bcm_pkg::*;
(
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // Requests from the core
    input wire logic start_i,
    input wire logic [1:0] channel_i,
    // Answer setup
    input wire logic [7:0] delay_i,
    input wire logic [13:0] volt_i,
    input wire logic [13:0] curr_i,
    input wire logic [13:0] temp_i,
    // Answers
    output logic done_o,
    output logic [13:0] data_o
);
    logic busy;
    logic [1:0] chan;
    logic [7:0] left;
    logic [13:0] noise;

    // Data is only valid with done; a changing pattern elsewhere exposes late sampling
    assign data_o = !done_o ? noise : (chan == CH_VOLT) ? volt_i : (chan == CH_CURR) ? curr_i : temp_i;

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            busy <= 1'b0;
            chan <= 2'h0;
            left <= 8'h0;
            noise <= 14'h0;
            done_o <= 1'b0;
        end else begin
            noise <= noise + 14'h1555;
            done_o <= 1'b0;
            if (start_i) begin
                busy <= 1'b1;
                chan <= channel_i;
                left <= delay_i;
            end else if (busy && left != 8'h0) begin
                left <= left - 8'h1;
            end else if (busy) begin
                busy <= 1'b0;
                done_o <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

//--- bcm_core.sv
// Digital core of the battery charge monitor
// Behaviour
// - Control bits [2:1] select alert output or charge-done input for the pin.
// - After reset the pin works in alert mode.
// - Alert mode: open-drain pin pulled low while any status flag is set.
// - Charge-done mode: low pin forces the accumulator to all ones.
// - Prescaler factor programmable from 1 to 4096.
// - Prescaler overflow increments, underflow decrements the accumulator.
// - Polarity from switch state and ramp direction at each reversal.
// - One count equals 0.340 mAh times 50 mOhm/Rsense times factor/4096.
// - Accumulator value is readable at any time.
// - Control write selecting manual mode starts the conversions.
// - Scan mode converts voltage, current, temperature every ten seconds.
// - Each conversion updates its result; converter sleeps after the temperature one.
// - 14, 12 and 11 bit results placed in 16-bit registers.
// - Reset loads defaults; counter runs, converter off.
// - Reset presets accumulator to mid-scale.
// - Reset clears low limits and sets high limits to all ones.
// - Reset enables alert and sets the factor to its maximum.
// - Limits compared continuously; flags set; pin low in alert mode.
`timescale 1ns/100ps
`default_nettype none
module bcm_core
    import bcm_pkg::*;
#(
    parameter longint SCAN_CYCLES = SCAN_PERIOD_CYCLES
) (
    // Clock and reset
    input wire logic CLOCK_I,
    input wire logic RST_I,
    // Integrator front end (asynchronous)
    input wire logic REVERSAL_I,
    input wire logic SWITCH_STATE_I,
    input wire logic RAMP_DIR_I,
    // Control register access
    input wire logic CTRL_WRITE_I,
    input wire logic [7:0] CTRL_DATA_I,
    output logic [7:0] CTRL_O,
    // Accumulator access
    input wire logic ACC_WRITE_I,
    input wire logic [15:0] ACC_DATA_I,
    output logic [15:0] ACC_O,
    // Limit table access
    input wire logic LIMIT_WRITE_I,
    input wire logic [2:0] LIMIT_SEL_I,
    input wire logic [15:0] LIMIT_DATA_I,
    // Status
    input wire logic STATUS_CLEAR_I,
    output logic [7:0] STATUS_O,
    // Converter handshake
    output logic ADC_START_O,
    output logic [1:0] ADC_CHANNEL_O,
    output logic ADC_SLEEP_O,
    input wire logic ADC_DONE_I,
    input wire logic [13:0] ADC_DATA_I,
    // Results
    output logic [15:0] VOLT_O,
    output logic [15:0] CURR_O,
    output logic [15:0] TEMP_O,
    // Alert or charge-done pin
    input wire logic ALERT_PIN_I,
    output logic ALERT_PIN_O,
    output logic ALERT_PIN_OE_O
);
    // ----------------------------------------------------------------
    // Input synchronisation and reversal edge
    // ----------------------------------------------------------------
    logic [3:0] fe_sync;
    logic rev_seen;
    logic rev_tick;
    logic count_up;
    logic pin_level;

    bcm_sync #(.WIDTH(4)) u_sync (
        .CLOCK_I(CLOCK_I),
        .RST_I(RST_I),
        .async_i({ALERT_PIN_I, RAMP_DIR_I, SWITCH_STATE_I, REVERSAL_I}),
        .sync_o(fe_sync)
    );

    assign pin_level = fe_sync[3];
    assign rev_tick = fe_sync[0] && !rev_seen;
    assign count_up = fe_sync[1] ^ fe_sync[2];

    // ----------------------------------------------------------------
    // Control register
    // ----------------------------------------------------------------
    logic [7:0] ctrl;
    logic [7:0] next_ctrl;
    logic [1:0] pin_mode;
    logic [1:0] adc_mode;
    logic alert_mode;
    logic charge_done_mode;
    logic [PRESCALE_W-1:0] factor;

    // Factor is 4 to the power of the code, capped at 4096
    function automatic logic [PRESCALE_W-1:0] prescale_factor(input logic [2:0] code);
        logic [3:0] shift;
        shift = {code, 1'b0};
        if (shift > PRESCALE_MAX_LOG2) begin
            shift = PRESCALE_MAX_LOG2;
        end
        return PRESCALE_W'(1) << shift;
    endfunction

    always_comb begin
        next_ctrl = ctrl;
        if (CTRL_WRITE_I) begin
            next_ctrl = CTRL_DATA_I;
        end
    end

    assign pin_mode = ctrl[CTRL_PIN_MSB:CTRL_PIN_LSB];
    assign adc_mode = ctrl[CTRL_ADC_MODE_MSB:CTRL_ADC_MODE_LSB];
    assign alert_mode = pin_mode == PIN_ALERT;
    assign charge_done_mode = pin_mode == PIN_CHARGE_DONE;
    assign factor = prescale_factor(ctrl[CTRL_PRESCALE_MSB:CTRL_PRESCALE_LSB]);

    // ----------------------------------------------------------------
    // Prescaler and charge accumulator
    // ----------------------------------------------------------------
    logic acc_over;
    logic acc_under;
    logic [15:0] acc;
    logic [15:0] next_acc;
    logic cc_force;

    bcm_prescaler u_prescaler (
        .CLOCK_I(CLOCK_I),
        .RST_I(RST_I),
        .tick_i(rev_tick && !ctrl[CTRL_HALT_BIT]),
        .up_i(count_up),
        .factor_i(factor),
        .over_o(acc_over),
        .under_o(acc_under)
    );

    // One count stands for 0.340 mAh * (50 mOhm / Rsense) * factor / 4096
    // Count weight follows factor
    assign cc_force = charge_done_mode && !pin_level;

    always_comb begin
        next_acc = acc;
        if (cc_force) begin
            next_acc = ACC_FULL;
        end else if (ACC_WRITE_I) begin
            next_acc = ACC_DATA_I;
        end else if (acc_over && acc != ACC_FULL) begin
            next_acc = acc + 16'h0001;
        end else if (acc_under && acc != ACC_EMPTY) begin
            next_acc = acc - 16'h0001;
        end
    end

    assign ACC_O = acc;
    assign CTRL_O = ctrl;

    // ----------------------------------------------------------------
    // Limit table
    // ----------------------------------------------------------------
    logic [15:0] limits [LIMIT_COUNT];
    logic [15:0] next_limits [LIMIT_COUNT];

    always_comb begin
        next_limits = limits;
        if (LIMIT_WRITE_I) begin
            next_limits[LIMIT_SEL_I] = LIMIT_DATA_I;
        end
    end

    // ----------------------------------------------------------------
    // Conversion sequencer
    // ----------------------------------------------------------------
    bcm_seq_type seq;
    bcm_seq_type next_seq;
    logic [1:0] chan;
    logic [1:0] next_chan;
    logic [29:0] scan_count;
    logic [29:0] next_scan_count;
    logic scan_due;
    logic manual_go;
    logic [15:0] volt;
    logic [15:0] curr;
    logic [15:0] temp;
    logic [15:0] next_volt;
    logic [15:0] next_curr;
    logic [15:0] next_temp;

    assign manual_go = CTRL_WRITE_I &&
        CTRL_DATA_I[CTRL_ADC_MODE_MSB:CTRL_ADC_MODE_LSB] == ADC_MODE_MANUAL;
    assign scan_due = adc_mode == ADC_MODE_SCAN && scan_count == 30'(SCAN_CYCLES - 1);

    always_comb begin
        next_seq = seq;
        next_chan = chan;
        next_scan_count = scan_count;
        next_volt = volt;
        next_curr = curr;
        next_temp = temp;
        if (adc_mode != ADC_MODE_SCAN || scan_due) begin
            next_scan_count = '0;
        end else begin
            next_scan_count = scan_count + 30'h00000001;
        end
        unique case (seq)
            SEQ_SLEEP: begin
                if (manual_go || scan_due || adc_mode == ADC_MODE_AUTO) begin
                    next_seq = SEQ_START;
                    next_chan = CH_VOLT;
                end
            end
            SEQ_START: begin
                next_seq = SEQ_WAIT;
            end
            SEQ_WAIT: begin
                if (ADC_DONE_I) begin
                    unique case (chan)
                        CH_VOLT: next_volt = {ADC_DATA_I, 2'h0};
                        CH_CURR: next_curr = {ADC_DATA_I[11:0], 4'h0};
                        default: next_temp = {ADC_DATA_I[10:0], 5'h00};
                    endcase
                    if (chan == CH_TEMP) begin
                        next_seq = SEQ_SLEEP;
                    end else begin
                        next_seq = SEQ_START;
                        next_chan = chan + 2'h1;
                    end
                end
            end
        endcase
    end

    assign ADC_START_O = seq == SEQ_START;
    assign ADC_CHANNEL_O = chan;
    assign ADC_SLEEP_O = seq == SEQ_SLEEP;
    assign VOLT_O = volt;
    assign CURR_O = curr;
    assign TEMP_O = temp;

    // ----------------------------------------------------------------
    // Limit monitor, status and pin
    // ----------------------------------------------------------------
    logic [7:0] status;
    logic [7:0] next_status;
    logic [7:0] events;

    function automatic logic outside(input logic [15:0] v, input logic [15:0] hi,
                                     input logic [15:0] lo);
        return v > hi || v < lo;
    endfunction

    always_comb begin
        events = 8'h00;
        events[ST_CHG_HI] = acc > limits[LIM_CHG_HI];
        events[ST_CHG_LO] = acc < limits[LIM_CHG_LO];
        events[ST_VOLT] = outside(volt, limits[LIM_VOLT_HI], limits[LIM_VOLT_LO]);
        events[ST_CURR] = outside(curr, limits[LIM_CURR_HI], limits[LIM_CURR_LO]);
        events[ST_TEMP] = outside(temp, limits[LIM_TEMP_HI], limits[LIM_TEMP_LO]);
        events[ST_ACC_LIMIT] = acc == ACC_FULL || acc == ACC_EMPTY;
        // A new event beats a clear in the same cycle
        next_status = (STATUS_CLEAR_I ? 8'h00 : status) | events;
    end

    assign STATUS_O = status;
    assign ALERT_PIN_O = 1'b0;
    assign ALERT_PIN_OE_O = alert_mode && status != 8'h00;

    // ----------------------------------------------------------------
    // State registers
    // ----------------------------------------------------------------
    // Power-on defaults
    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            ctrl <= CTRL_RESET;
            acc <= ACC_RESET;
            rev_seen <= 1'b0;
            seq <= SEQ_SLEEP;
            chan <= CH_VOLT;
            scan_count <= '0;
            volt <= 16'h0000;
            curr <= 16'h0000;
            temp <= 16'h0000;
            status <= 8'h00;
            for (int i = 0; i < LIMIT_COUNT; i++) begin
                limits[i] <= i[0] ? LIMIT_LOW_RESET : LIMIT_HIGH_RESET;
            end
        end else begin
            ctrl <= next_ctrl;
            acc <= next_acc;
            rev_seen <= fe_sync[0];
            seq <= next_seq;
            chan <= next_chan;
            scan_count <= next_scan_count;
            volt <= next_volt;
            curr <= next_curr;
            temp <= next_temp;
            status <= next_status;
            limits <= next_limits;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    sequence s_start_then_wait;
        ADC_START_O ##1 (seq == SEQ_WAIT && !ADC_START_O);
    endsequence

    sequence s_last_done;
        seq == SEQ_WAIT && ADC_DONE_I && chan == CH_TEMP;
    endsequence

    a_cc_fills_acc: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        cc_force |=> acc == ACC_FULL)
        else $error("charge done did not fill accumulator");

    a_acc_step_up: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        acc_over && !cc_force && !ACC_WRITE_I && acc != ACC_FULL |=> acc == $past(acc) + 16'h1)
        else $error("overflow did not increment");

    a_acc_step_down: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        acc_under && !cc_force && !ACC_WRITE_I && acc != ACC_EMPTY |=> acc == $past(acc) - 16'h1)
        else $error("underflow did not decrement");

    a_acc_saturate: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        acc == ACC_FULL && acc_over && !ACC_WRITE_I |=> acc == ACC_FULL)
        else $error("accumulator wrapped at top");

    a_alert_drive: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        alert_mode && events != 8'h00 |=> !alert_mode || (ALERT_PIN_OE_O && !ALERT_PIN_O))
        else $error("alert pin not pulled low");

    a_cc_no_drive: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        charge_done_mode |-> !ALERT_PIN_OE_O)
        else $error("pin driven in charge done mode");

    a_manual_start: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        seq == SEQ_SLEEP && manual_go |=> s_start_then_wait)
        else $error("control write did not start conversion");

    a_sleep_after: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        s_last_done |=> ADC_SLEEP_O && $changed(temp) || ADC_SLEEP_O)
        else $error("converter not asleep after last result");

    a_volt_result: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        seq == SEQ_WAIT && ADC_DONE_I && chan == CH_VOLT |=> volt == {$past(ADC_DATA_I), 2'h0})
        else $error("voltage result misplaced");

    a_status_sticky: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        events[ST_VOLT] |=> status[ST_VOLT] [*2] or STATUS_CLEAR_I ##1 1'b1)
        else $error("status flag lost");
endmodule
`default_nettype wire

//--- bcm_pkg.sv
// Shared constants and types of the battery charge monitor core
package bcm_pkg;

    // ----------------------------------------------------------------
    // Clock and timing
    // ----------------------------------------------------------------
    localparam longint CLOCK_HZ = 100_000_000;
    localparam longint SCAN_PERIOD_S = 10;
    localparam longint SCAN_PERIOD_CYCLES = SCAN_PERIOD_S * CLOCK_HZ;

    // ----------------------------------------------------------------
    // Control register layout and reset value
    // ----------------------------------------------------------------
    localparam logic [7:0] CTRL_RESET = 8'h3c;
    localparam int CTRL_ADC_MODE_MSB = 7;
    localparam int CTRL_ADC_MODE_LSB = 6;
    localparam int CTRL_PRESCALE_MSB = 5;
    localparam int CTRL_PRESCALE_LSB = 3;
    localparam int CTRL_PIN_MSB = 2;
    localparam int CTRL_PIN_LSB = 1;
    localparam int CTRL_HALT_BIT = 0;

    // Pin function codes in control bits [2:1]
    localparam logic [1:0] PIN_ALERT = 2'h2;
    localparam logic [1:0] PIN_CHARGE_DONE = 2'h1;

    // Converter mode codes in control bits [7:6]
    localparam logic [1:0] ADC_MODE_SLEEP = 2'h0;
    localparam logic [1:0] ADC_MODE_MANUAL = 2'h1;
    localparam logic [1:0] ADC_MODE_SCAN = 2'h2;
    localparam logic [1:0] ADC_MODE_AUTO = 2'h3;

    // ----------------------------------------------------------------
    // Prescaler and accumulator
    // ----------------------------------------------------------------
    localparam int PRESCALE_W = 13;
    localparam logic [3:0] PRESCALE_MAX_LOG2 = 4'hc;
    localparam logic [15:0] ACC_RESET = 16'h7fff;
    localparam logic [15:0] ACC_FULL = 16'hffff;
    localparam logic [15:0] ACC_EMPTY = 16'h0000;
    localparam logic [15:0] LIMIT_LOW_RESET = 16'h0000;
    localparam logic [15:0] LIMIT_HIGH_RESET = 16'hffff;

    // ----------------------------------------------------------------
    // Limit table index and status flag positions
    // ----------------------------------------------------------------
    localparam int LIMIT_COUNT = 8;
    localparam logic [2:0] LIM_CHG_HI = 3'h0;
    localparam logic [2:0] LIM_CHG_LO = 3'h1;
    localparam logic [2:0] LIM_VOLT_HI = 3'h2;
    localparam logic [2:0] LIM_VOLT_LO = 3'h3;
    localparam logic [2:0] LIM_CURR_HI = 3'h4;
    localparam logic [2:0] LIM_CURR_LO = 3'h5;
    localparam logic [2:0] LIM_TEMP_HI = 3'h6;
    localparam logic [2:0] LIM_TEMP_LO = 3'h7;
    localparam int ST_VOLT = 1;
    localparam int ST_CHG_LO = 2;
    localparam int ST_CHG_HI = 3;
    localparam int ST_TEMP = 4;
    localparam int ST_ACC_LIMIT = 5;
    localparam int ST_CURR = 6;

    // Converter channels in conversion order
    localparam logic [1:0] CH_VOLT = 2'h0;
    localparam logic [1:0] CH_CURR = 2'h1;
    localparam logic [1:0] CH_TEMP = 2'h2;

    typedef enum logic [1:0] {SEQ_SLEEP, SEQ_START, SEQ_WAIT} bcm_seq_type;

endpackage

//--- bcm_prescaler.sv
// Up/down prescaler between integrator reversals and the accumulator
`timescale 1ns/100ps
`default_nettype none
module bcm_prescaler
    import bcm_pkg::*;
(
    // Clock and reset
    input wire logic CLOCK_I,
    input wire logic RST_I,
    // Events
    input wire logic tick_i,
    input wire logic up_i,
    input wire logic [PRESCALE_W-1:0] factor_i,
    output logic over_o,
    output logic under_o
);
    logic [PRESCALE_W-1:0] count;
    logic [PRESCALE_W-1:0] next_count;
    logic [PRESCALE_W-1:0] top;

    assign top = factor_i - PRESCALE_W'(1);

    always_comb begin
        next_count = count;
        over_o = 1'b0;
        under_o = 1'b0;
        if (count > top) begin
            // Factor was lowered below the running count
            next_count = '0;
        end else if (tick_i && up_i) begin
            if (count == top) begin
                next_count = '0;
                over_o = 1'b1;
            end else begin
                next_count = count + PRESCALE_W'(1);
            end
        end else if (tick_i) begin
            if (count == '0) begin
                next_count = top;
                under_o = 1'b1;
            end else begin
                next_count = count - PRESCALE_W'(1);
            end
        end
    end

    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    a_over_wraps: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        over_o |=> count == '0)
        else $error("prescaler did not wrap after overflow");

    a_under_reload: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        under_o && $stable(factor_i) ##1 $stable(factor_i) |-> count == top)
        else $error("prescaler did not reload after underflow");
endmodule
`default_nettype wire

//--- bcm_sync.sv
// Two-stage synchroniser for asynchronous level inputs
`timescale 1ns/100ps
`default_nettype none
module bcm_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic CLOCK_I,
    input wire logic RST_I,
    // Levels
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;

    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            stage1 <= '0;
            stage2 <= '0;
        end else begin
            stage1 <= async_i;
            stage2 <= stage1;
        end
    end

    assign sync_o = stage2;
endmodule
`default_nettype wire

//--- test_bcm_core.sv
// Self-checking bench for the battery charge monitor core
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
    $display("mismatch %s expected %h seen %h", n, e, g); end end
module test_bcm_core
    import bcm_pkg::*;
;
    typedef struct packed {
        logic [2:0] code;
        logic sw;
        logic ramp;
        logic [7:0] n;
        logic [15:0] start;
        logic [15:0] exp;
    } bcm_row_type;
    localparam bcm_row_type ROWS [6] = '{
        '{3'h0, 1'h1, 1'h0, 8'h3, 16'h1000, 16'h1003},
        '{3'h0, 1'h0, 1'h1, 8'h3, 16'h1000, 16'h1003},
        '{3'h0, 1'h1, 1'h1, 8'h2, 16'h1000, 16'h0ffe},
        '{3'h1, 1'h0, 1'h1, 8'h8, 16'h1000, 16'h1002},
        '{3'h0, 1'h1, 1'h0, 8'h3, 16'hfffe, 16'hffff},
        '{3'h0, 1'h0, 1'h0, 8'h3, 16'h0001, 16'h0000}
    };
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic rev = 1'b0, sw = 1'b0, ramp = 1'b0, cw = 1'b0, aw = 1'b0, lw = 1'b0, sc = 1'b0;
    logic charger = 1'b1;
    logic pin, start, sleep, done, pin_o, oe;
    logic [1:0] ch;
    logic [2:0] ls = 3'h0;
    logic [7:0] cd = 8'h3c, dly = 8'h2, ctrl, status;
    logic [13:0] adata, dv = 14'h2abc, dc = 14'h1123, dt = 14'h0456;
    logic [15:0] ad = 16'h0, ld = 16'h0, acc, volt, curr, temp;
    int mismatches = 0, samples_checked = 0, cycles = 0;

    // Open-drain pin: low if the core pulls or the charger holds it low
    assign pin = !(oe || !charger);

    bcm_core #(.SCAN_CYCLES(200)) u_bcm_core (.CLOCK_I(clock), .RST_I(rst),
        .REVERSAL_I(rev), .SWITCH_STATE_I(sw), .RAMP_DIR_I(ramp), .CTRL_WRITE_I(cw),
        .CTRL_DATA_I(cd), .CTRL_O(ctrl), .ACC_WRITE_I(aw), .ACC_DATA_I(ad), .ACC_O(acc),
        .LIMIT_WRITE_I(lw), .LIMIT_SEL_I(ls), .LIMIT_DATA_I(ld), .STATUS_CLEAR_I(sc),
        .STATUS_O(status), .ADC_START_O(start), .ADC_CHANNEL_O(ch), .ADC_SLEEP_O(sleep),
        .ADC_DONE_I(done), .ADC_DATA_I(adata), .VOLT_O(volt), .CURR_O(curr), .TEMP_O(temp),
        .ALERT_PIN_I(pin), .ALERT_PIN_O(pin_o), .ALERT_PIN_OE_O(oe));
    bcm_adc_model u_bcm_adc_model (.clock_i(clock), .rst_i(rst), .start_i(start),
        .channel_i(ch), .delay_i(dly), .volt_i(dv), .curr_i(dc), .temp_i(dt),
        .done_o(done), .data_o(adata));

    initial begin
        forever #5 clock = ~clock;
    end

    // Whole run needs about 800 cycles; the ceiling leaves wide margin
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            stop_test();
        end
    end

    task automatic tick(input int n);
        repeat (n) @(negedge clock);
    endtask

    // Kind 0 control, 1 accumulator, 2 limit, 3 status clear
    task automatic wr(input logic [1:0] k, input logic [15:0] v, input logic [2:0] s);
        cd = v[7:0];
        ad = v;
        ld = v;
        ls = s;
        cw = (k == 2'h0);
        aw = (k == 2'h1);
        lw = (k == 2'h2);
        sc = (k == 2'h3);
        tick(1);
        {cw, aw, lw, sc} = 4'h0;
        // Idle cycle so a following call never re-raises a strobe in the same step
        tick(1);
    endtask

    task automatic wait_sleep(input logic v);
        for (int k = 0; k < 400 && sleep !== v; k++) tick(1);
    endtask

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        tick(6);
        rst = 1'b0;
        tick(1);
        `CHK("ctrl", CTRL_RESET, ctrl)
        `CHK("acc", ACC_RESET, acc)
        `CHK("sleep", 1'b1, sleep)
        `CHK("status", 8'h0, status)
        `CHK("oe", 1'b0, oe)
        $display("reset test done");
        foreach (ROWS[i]) begin
            wr(2'h0, {8'h0, ADC_MODE_SLEEP, ROWS[i].code, PIN_ALERT, 1'b0}, 3'h0);
            wr(2'h1, ROWS[i].start, 3'h0);
            sw = ROWS[i].sw;
            ramp = ROWS[i].ramp;
            // Reversals run on their own 125 ns period, unrelated to the core clock
            repeat (ROWS[i].n) begin
                #62.5 rev = 1'b1;
                #62.5 rev = 1'b0;
            end
            tick(12);
            `CHK("acc", ROWS[i].exp, acc)
            $display("count row %0d done", i);
        end
        wr(2'h0, {8'h0, ADC_MODE_SLEEP, 3'h7, PIN_CHARGE_DONE, 1'b0}, 3'h0);
        `CHK("oe", 1'b0, oe)
        charger = 1'b0;
        tick(5);
        `CHK("acc", ACC_FULL, acc)
        charger = 1'b1;
        // Released pin needs the synchroniser delay, or the force beats the write
        tick(3);
        wr(2'h1, 16'h0800, 3'h0);
        wr(2'h3, 16'h0, 3'h0);
        wr(2'h0, {8'h0, ADC_MODE_SLEEP, 3'h7, PIN_ALERT, 1'b0}, 3'h0);
        tick(3);
        `CHK("oe", 1'b0, oe)
        wr(2'h2, 16'h0400, LIM_CHG_HI);
        tick(3);
        `CHK("flag", 1'b1, status[ST_CHG_HI])
        `CHK("oe", 1'b1, oe)
        `CHK("pin_o", 1'b0, pin_o)
        $display("pin test done");
        wr(2'h0, {8'h0, ADC_MODE_MANUAL, 3'h7, PIN_ALERT, 1'b0}, 3'h0);
        `CHK("sleep", 1'b0, sleep)
        wait_sleep(1'b1);
        `CHK("volt", {dv, 2'h0}, volt)
        `CHK("curr", {dc[11:0], 4'h0}, curr)
        `CHK("temp", {dt[10:0], 5'h0}, temp)
        wr(2'h2, 16'h1000, LIM_VOLT_HI);
        `CHK("flag", 1'b1, status[ST_VOLT])
        $display("manual test done");
        {dly, dv, dc, dt} = {8'h14, 14'h1357, 14'h0246, 14'h07ad};
        wr(2'h0, {8'h0, ADC_MODE_SCAN, 3'h7, PIN_ALERT, 1'b0}, 3'h0);
        tick(100);
        `CHK("volt", {14'h2abc, 2'h0}, volt)
        tick(250);
        `CHK("volt", {dv, 2'h0}, volt)
        `CHK("temp", {dt[10:0], 5'h0}, temp)
        `CHK("sleep", 1'b1, sleep)
        $display("scan test done");
        rst = 1'b1;
        tick(2);
        `CHK("acc", ACC_RESET, acc)
        `CHK("ctrl", CTRL_RESET, ctrl)
        `CHK("volt", 16'h0, volt)
        rst = 1'b0;
        tick(2);
        wr(2'h1, 16'hfffe, 3'h0);
        tick(3);
        `CHK("status", 8'h0, status)
        $display("second reset test done");
        stop_test();
    end
endmodule
`default_nettype wire
